// ===== dsc_drive_stop.sv
`timescale 1ns/10ps
module dsc_drive_stop
  import dsc_pkg::*;
#(
  parameter int N_HALT_PINS = 2
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Parameter access
  input wire dsc_param_req_t param_req_in,
  input wire logic [15:0] param_rd_addr_in,
  output logic [31:0] param_rdata_out,
  // Same-domain events and requests
  input wire dsc_event_t event_in,
  input wire logic halt_sw_in,
  input wire logic [15:0] ref_speed_in,
  input wire logic [31:0] accel_ramp_in,
  // Pins from outside
  input wire logic [N_HALT_PINS-1:0] halt_pin_in,
  input wire logic dc_overvolt_in,
  // Drive side
  output logic [DSC_SPD_W-1:0] speed_out,
  output logic [31:0] active_ramp_out,
  output logic power_stage_en_out,
  output logic position_ctrl_out,
  output logic pos_adjust_out,
  output dsc_status_t status_out
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [N_HALT_PINS:0] sync1_reg;
  logic [N_HALT_PINS:0] sync2_reg;
  logic [N_HALT_PINS:0] sync1_next;
  logic [N_HALT_PINS:0] sync2_next;

  // Two stages for halt pins and overvoltage
  always_comb begin
    sync1_next = {dc_overvolt_in, halt_pin_in};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  logic halt_any;
  logic overvolt;

  // Any source requests halt alike
  assign halt_any = halt_sw_in | (|sync2_reg[N_HALT_PINS-1:0]);
  assign overvolt = sync2_reg[N_HALT_PINS];

  // ------------------------------------------------------------
  // Ramp parameters
  // ------------------------------------------------------------
  logic [31:0] profile_decel_ramp_reg;
  logic [31:0] profile_decel_ramp_next;
  logic [31:0] quick_stop_decel_ramp_reg;
  logic [31:0] quick_stop_decel_ramp_next;
  logic wdata_ok;

  // Writes outside the permitted range are ignored
  always_comb begin
    wdata_ok = (param_req_in.wdata >= DSC_RAMP_MIN) &&
               (param_req_in.wdata <= DSC_RAMP_MAX);
    profile_decel_ramp_next = profile_decel_ramp_reg;
    quick_stop_decel_ramp_next = quick_stop_decel_ramp_reg;
    if (param_req_in.wr && wdata_ok) begin
      if (param_req_in.addr == DSC_ADDR_PROFILE_DECEL) begin
        profile_decel_ramp_next = param_req_in.wdata;
      end else if (param_req_in.addr == DSC_ADDR_QUICK_STOP_DECEL) begin
        quick_stop_decel_ramp_next = param_req_in.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      profile_decel_ramp_reg <= DSC_PROFILE_DECEL_RST;
      quick_stop_decel_ramp_reg <= DSC_QUICK_STOP_DECEL_RST;
    end else begin
      profile_decel_ramp_reg <= profile_decel_ramp_next;
      quick_stop_decel_ramp_reg <= quick_stop_decel_ramp_next;
    end
  end

  // Read data, zero for unmapped addresses
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    if (param_rd_addr_in == DSC_ADDR_PROFILE_DECEL) begin
      rdata_next = profile_decel_ramp_reg;
    end else if (param_rd_addr_in == DSC_ADDR_QUICK_STOP_DECEL) begin
      rdata_next = quick_stop_decel_ramp_reg;
    end else begin
      rdata_next = 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign param_rdata_out = rdata_reg;

  // ------------------------------------------------------------
  // Stop state machine and speed profile
  // ------------------------------------------------------------
  dsc_state_t state_reg;
  dsc_state_t state_next;
  logic [DSC_SPD_W-1:0] speed_reg;
  logic [DSC_SPD_W-1:0] speed_next;
  logic [31:0] ramp_reg;
  logic [31:0] ramp_next;
  logic power_reg;
  logic power_next;
  logic posctl_reg;
  logic posctl_next;
  logic adjust_reg;
  logic adjust_next;
  logic ov_fault_reg;
  logic ov_fault_next;
  logic class2_reg;
  logic class2_next;
  logic [DSC_SPD_W-1:0] target;
  logic [DSC_SPD_W-1:0] decel_step;
  logic [DSC_SPD_W-1:0] decel_rate;
  logic [DSC_SPD_W-1:0] accel_sum;
  logic qs_trigger;
  logic at_rest;

  always_comb begin
    target = 40'(ref_speed_in) * DSC_SPD_SCALE;
    qs_trigger = event_in.sw_quick_stop | event_in.err_class1 |
                 event_in.err_class2;
    at_rest = (speed_reg == DSC_SPD_ZERO);
    state_next = state_reg;
    ramp_next = ramp_reg;
    power_next = power_reg;
    posctl_next = posctl_reg;
    adjust_next = 1'b0;
    ov_fault_next = ov_fault_reg;
    class2_next = class2_reg | event_in.err_class2;
    // Ramp choice for this cycle
    if (state_reg == DSC_ST_QS_DECEL || qs_trigger) begin
      decel_rate = 40'(quick_stop_decel_ramp_reg);
    end else begin
      decel_rate = 40'(profile_decel_ramp_reg);
    end
    decel_step = (speed_reg > decel_rate) ? speed_reg - decel_rate :
                 DSC_SPD_ZERO;
    accel_sum = speed_reg + 40'(accel_ramp_in);
    speed_next = speed_reg;

    case (state_reg)
      DSC_ST_RUN: begin
        posctl_next = 1'b0;
        if (speed_reg > target) begin
          speed_next = (decel_step > target) ? decel_step : target;
        end else begin
          speed_next = (accel_sum < target) ? accel_sum : target;
        end
        if (qs_trigger) begin
          state_next = DSC_ST_QS_DECEL;
          ramp_next = quick_stop_decel_ramp_reg;
          speed_next = decel_step;
        end else if (halt_any) begin
          state_next = DSC_ST_HALT_DECEL;
          ramp_next = profile_decel_ramp_reg;
          speed_next = decel_step;
        end
      end
      DSC_ST_HALT_DECEL: begin
        speed_next = decel_step;
        if (qs_trigger) begin
          state_next = DSC_ST_QS_DECEL;
          ramp_next = quick_stop_decel_ramp_reg;
        end else if (!halt_any) begin
          state_next = DSC_ST_RUN;
          speed_next = speed_reg;
        end else if (decel_step == DSC_SPD_ZERO) begin
          state_next = DSC_ST_HALT_ADJ;
          adjust_next = 1'b1;
        end
      end
      DSC_ST_HALT_ADJ: begin
        speed_next = DSC_SPD_ZERO;
        if (qs_trigger) begin
          state_next = DSC_ST_QS_DECEL;
          ramp_next = quick_stop_decel_ramp_reg;
        end else begin
          state_next = DSC_ST_HALT_HOLD;
          posctl_next = 1'b1;
        end
      end
      DSC_ST_HALT_HOLD: begin
        speed_next = DSC_SPD_ZERO;
        if (qs_trigger) begin
          state_next = DSC_ST_QS_DECEL;
          ramp_next = quick_stop_decel_ramp_reg;
        end else if (!halt_any) begin
          state_next = DSC_ST_RUN;
          posctl_next = 1'b0;
        end
      end
      DSC_ST_QS_DECEL: begin
        speed_next = decel_step;
        if (decel_step == DSC_SPD_ZERO) begin
          if (class2_next) begin
            state_next = DSC_ST_QS_OFF;
            power_next = 1'b0;
          end else begin
            state_next = DSC_ST_QS_HOLD;
            posctl_next = 1'b1;
          end
        end
      end
      DSC_ST_QS_HOLD: begin
        speed_next = DSC_SPD_ZERO;
        if (event_in.fault_reset && !qs_trigger) begin
          state_next = DSC_ST_RUN;
          class2_next = 1'b0;
        end else if (event_in.err_class2) begin
          state_next = DSC_ST_QS_OFF;
          power_next = 1'b0;
        end
      end
      DSC_ST_QS_OFF: begin
        speed_next = DSC_SPD_ZERO;
        if (event_in.fault_reset && !qs_trigger) begin
          state_next = DSC_ST_RUN;
          power_next = 1'b1;
          class2_next = 1'b0;
        end
      end
      DSC_ST_COAST: begin
        speed_next = DSC_SPD_ZERO;
        if (event_in.fault_reset && !overvolt && !qs_trigger) begin
          state_next = DSC_ST_RUN;
          power_next = 1'b1;
          ov_fault_next = 1'b0;
          class2_next = 1'b0;
        end
      end
      default: begin
        state_next = DSC_ST_RUN;
      end
    endcase

    // Overvoltage during braking overrides everything
    if (overvolt && state_reg != DSC_ST_COAST &&
        (state_reg == DSC_ST_QS_DECEL || state_reg == DSC_ST_HALT_DECEL ||
         speed_reg > target)) begin
      state_next = DSC_ST_COAST;
      power_next = 1'b0;
      posctl_next = 1'b0;
      ov_fault_next = 1'b1;
      speed_next = DSC_SPD_ZERO;
      adjust_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= DSC_ST_RUN;
      speed_reg <= DSC_SPD_ZERO;
      ramp_reg <= DSC_PROFILE_DECEL_RST;
      power_reg <= 1'b1;
      posctl_reg <= 1'b0;
      adjust_reg <= 1'b0;
      ov_fault_reg <= 1'b0;
      class2_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      speed_reg <= speed_next;
      ramp_reg <= ramp_next;
      power_reg <= power_next;
      posctl_reg <= posctl_next;
      adjust_reg <= adjust_next;
      ov_fault_reg <= ov_fault_next;
      class2_reg <= class2_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign speed_out = speed_reg;
  assign active_ramp_out = ramp_reg;
  assign power_stage_en_out = power_reg;
  assign position_ctrl_out = posctl_reg;
  assign pos_adjust_out = adjust_reg;

  // Status from registered state
  always_comb begin
    status_out.quick_stop_active = (state_reg == DSC_ST_QS_DECEL) ||
                                   (state_reg == DSC_ST_QS_HOLD) ||
                                   (state_reg == DSC_ST_QS_OFF);
    status_out.halt_active = (state_reg == DSC_ST_HALT_DECEL) ||
                             (state_reg == DSC_ST_HALT_ADJ) ||
                             (state_reg == DSC_ST_HALT_HOLD);
    status_out.standstill = at_rest;
    status_out.dc_overvolt_fault = ov_fault_reg;
    status_out.class2_pending = class2_reg;
  end

endmodule

// ===== dsc_motor_model.sv
`timescale 1ns/10ps
module dsc_motor_model
  import dsc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [DSC_SPD_W-1:0] speed_in,
  input wire logic power_en_in,
  input wire logic trip_en_in,
  output logic dc_overvolt_out
);
  logic [DSC_SPD_W-1:0] last_reg;
  // Bus overshoots when braking with power on, when armed, and stays high until disarmed
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_reg <= DSC_SPD_ZERO;
      dc_overvolt_out <= 1'b0;
    end else begin
      last_reg <= speed_in;
      dc_overvolt_out <= trip_en_in && (dc_overvolt_out
        || (power_en_in && speed_in < last_reg));
    end
  end
endmodule

// ===== dsc_pkg.sv
package dsc_pkg;

  // ------------------------------------------------------------
  // Parameter addresses and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] DSC_ADDR_PROFILE_DECEL = 16'h0616;
  localparam logic [15:0] DSC_ADDR_QUICK_STOP_DECEL = 16'h0624;
  localparam logic [31:0] DSC_PROFILE_DECEL_RST = 32'h0000_02ee;
  localparam logic [31:0] DSC_QUICK_STOP_DECEL_RST = 32'h0000_1770;
  localparam logic [31:0] DSC_RAMP_MIN = 32'h0000_00c8;
  localparam logic [31:0] DSC_RAMP_MAX = 32'h002d_c6c0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned DSC_CLK_HZ = 10_000_000;
  localparam int DSC_SPD_W = 40;
  localparam logic [DSC_SPD_W-1:0] DSC_SPD_SCALE = 40'(DSC_CLK_HZ);
  localparam logic [DSC_SPD_W-1:0] DSC_SPD_ZERO = 40'h00_0000_0000;

  // ------------------------------------------------------------
  // Stop control state, one-hot
  // ------------------------------------------------------------
  typedef enum logic [7:0] {
    DSC_ST_RUN = 8'h01,
    DSC_ST_HALT_DECEL = 8'h02,
    DSC_ST_HALT_ADJ = 8'h04,
    DSC_ST_HALT_HOLD = 8'h08,
    DSC_ST_QS_DECEL = 8'h10,
    DSC_ST_QS_HOLD = 8'h20,
    DSC_ST_QS_OFF = 8'h40,
    DSC_ST_COAST = 8'h80
  } dsc_state_t;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic sw_quick_stop;
    logic err_class1;
    logic err_class2;
    logic fault_reset;
  } dsc_event_t;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } dsc_param_req_t;

  typedef struct packed {
    logic quick_stop_active;
    logic halt_active;
    logic standstill;
    logic dc_overvolt_fault;
    logic class2_pending;
  } dsc_status_t;

endpackage

// ===== dsc_stop_props.sv
`timescale 1ns/10ps
module dsc_stop_props
  import dsc_pkg::*;
#(
  parameter int N_HALT_PINS = 2
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire dsc_param_req_t param_req_in,
  input wire logic [15:0] param_rd_addr_in,
  input wire logic [31:0] param_rdata_out,
  input wire dsc_event_t event_in,
  input wire logic halt_sw_in,
  input wire logic [N_HALT_PINS-1:0] halt_pin_in,
  input wire logic [DSC_SPD_W-1:0] speed_out,
  input wire logic [31:0] active_ramp_out,
  input wire logic power_stage_en_out,
  input wire logic position_ctrl_out,
  input wire logic pos_adjust_out,
  input wire dsc_status_t status_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  logic [31:0] qs_ramp_reg, qs_ramp_next;
  logic [DSC_SPD_W-1:0] step_reg, step_next;
  logic wr_ok;
  // Shadow quick-stop ramp and expected decel step
  always_comb begin
    wr_ok = param_req_in.wr && param_req_in.wdata >= DSC_RAMP_MIN
      && param_req_in.wdata <= DSC_RAMP_MAX;
    qs_ramp_next = qs_ramp_reg;
    if (wr_ok && param_req_in.addr == DSC_ADDR_QUICK_STOP_DECEL) begin
      qs_ramp_next = param_req_in.wdata;
    end
    step_next = DSC_SPD_ZERO;
    if (speed_out > 40'(active_ramp_out)) begin
      step_next = speed_out - 40'(active_ramp_out);
    end
  end
  // Register helpers
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      qs_ramp_reg <= DSC_QUICK_STOP_DECEL_RST;
      step_reg <= DSC_SPD_ZERO;
    end else begin
      qs_ramp_reg <= qs_ramp_next;
      step_reg <= step_next;
    end
  end
  // ------------------------------------------------------------
  // Sequences and assertions
  // ------------------------------------------------------------
  sequence s_halt_dec;
    status_out.halt_active && !position_ctrl_out && halt_sw_in
      && speed_out != DSC_SPD_ZERO && event_in == '0;
  endsequence
  sequence s_halt_zero;
    status_out.halt_active && halt_sw_in && speed_out == DSC_SPD_ZERO
      && !position_ctrl_out && !status_out.dc_overvolt_fault;
  endsequence
  sequence s_all_clear;
    (!halt_sw_in && halt_pin_in == '0)[*3];
  endsequence
  a_qs_take: assert property ((event_in.sw_quick_stop
    || event_in.err_class1 || event_in.err_class2)
    && !status_out.dc_overvolt_fault
    |=> status_out.quick_stop_active) else $error("quick stop not taken");
  a_qs_ramp_pick: assert property ($rose(status_out.quick_stop_active)
    |-> active_ramp_out == qs_ramp_reg) else $error("wrong quick stop ramp");
  a_qs_latch: assert property (status_out.quick_stop_active
    && !event_in.fault_reset |=> status_out.quick_stop_active
    || status_out.dc_overvolt_fault) else $error("quick stop dropped");
  a_class1_power: assert property (status_out.quick_stop_active
    && !status_out.class2_pending && !status_out.dc_overvolt_fault
    |-> power_stage_en_out) else $error("power lost in class 1 stop");
  a_off_at_rest: assert property (!power_stage_en_out
    && !status_out.dc_overvolt_fault |-> status_out.standstill)
    else $error("power off while moving");
  a_ov_coast: assert property (status_out.dc_overvolt_fault
    |-> !power_stage_en_out && speed_out == DSC_SPD_ZERO)
    else $error("overvoltage without coast");
  a_halt_step: assert property (s_halt_dec |=>
    status_out.dc_overvolt_fault || speed_out == step_reg)
    else $error("halt decel step wrong");
  a_halt_adjust: assert property (s_halt_zero
    |-> ##[0:1] pos_adjust_out ##1 (position_ctrl_out && power_stage_en_out))
    else $error("halt standstill sequence wrong");
  a_halt_release: assert property (s_all_clear
    ##0 (status_out.halt_active && event_in == '0
    && !status_out.dc_overvolt_fault)
    |-> ##[1:2] !status_out.halt_active) else $error("halt not released");
  a_param_read: assert property ((wr_ok
    && param_req_in.addr == DSC_ADDR_PROFILE_DECEL) ##1 (!param_req_in.wr
    && param_rd_addr_in == DSC_ADDR_PROFILE_DECEL)
    |=> param_rdata_out == $past(param_req_in.wdata, 2))
    else $error("profile ramp readback wrong");
endmodule
bind dsc_drive_stop dsc_stop_props #(.N_HALT_PINS(N_HALT_PINS)) u_props (
  .sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in),
  .param_req_in(param_req_in),
  .param_rd_addr_in(param_rd_addr_in),
  .param_rdata_out(param_rdata_out),
  .event_in(event_in),
  .halt_sw_in(halt_sw_in),
  .halt_pin_in(halt_pin_in),
  .speed_out(speed_out),
  .active_ramp_out(active_ramp_out),
  .power_stage_en_out(power_stage_en_out),
  .position_ctrl_out(position_ctrl_out),
  .pos_adjust_out(pos_adjust_out),
  .status_out(status_out)
);

// ===== tb_drive_stop_control.sv
`timescale 1ns/10ps
module tb_drive_stop_control;
  import dsc_pkg::*;
  logic sys_clk_in = 0, rstn_in = 0, halt_sw_in = 0, trip = 0, ov;
  dsc_param_req_t param_req_in = '0;
  dsc_event_t event_in = '0;
  logic [15:0] param_rd_addr_in = '0, ref_speed_in = '0;
  logic [31:0] accel_ramp_in = 32'h02fa_f080, param_rdata_out, ramp_out;
  logic [1:0] halt_pin_in = '0;
  logic [DSC_SPD_W-1:0] speed_out;
  logic power_out, pos_ctrl_out, adj_out;
  dsc_status_t st;
  int err_count = 0, samples_checked = 0;
  logic [31:0] seed = 32'h360b6a9c;
  always #50 sys_clk_in = ~sys_clk_in;
  dsc_drive_stop u_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .param_req_in(param_req_in), .param_rd_addr_in(param_rd_addr_in),
    .param_rdata_out(param_rdata_out), .event_in(event_in),
    .halt_sw_in(halt_sw_in), .ref_speed_in(ref_speed_in),
    .accel_ramp_in(accel_ramp_in), .halt_pin_in(halt_pin_in),
    .dc_overvolt_in(ov), .speed_out(speed_out), .active_ramp_out(ramp_out),
    .power_stage_en_out(power_out), .position_ctrl_out(pos_ctrl_out),
    .pos_adjust_out(adj_out), .status_out(st));
  dsc_motor_model u_motor (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .speed_in(speed_out), .power_en_in(power_out), .trip_en_in(trip),
    .dc_overvolt_out(ov));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [39:0] target(logic [15:0] rpm);
    return 40'(rpm) * DSC_SPD_SCALE;
  endfunction
  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [31:0] d);
    param_req_in = '{1'b1, a, d};
    tick();
    param_req_in.wr = 1'b0;
    tick();
  endtask
  task automatic rd(logic [15:0] a, logic [31:0] exp);
    param_rd_addr_in = a;
    tick(2);
    check("param read", 64'(exp), 64'(param_rdata_out));
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #(6000 * 100);
    err_count++;
    test_done();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [39:0] tgt, s;
    logic [31:0] v, q;
    tick(12);
    rstn_in = 1'b1;
    tick();
    rd(DSC_ADDR_PROFILE_DECEL, DSC_PROFILE_DECEL_RST);
    rd(DSC_ADDR_QUICK_STOP_DECEL, DSC_QUICK_STOP_DECEL_RST);
    check("power at reset", 1, 64'(power_out));
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      v = k == 0 ? DSC_RAMP_MIN : k == 1 ? DSC_RAMP_MAX :
        DSC_RAMP_MIN + seed % 32'd2999801;
      wr(DSC_ADDR_PROFILE_DECEL, v);
      rd(DSC_ADDR_PROFILE_DECEL, v);
    end
    wr(DSC_ADDR_PROFILE_DECEL, DSC_RAMP_MIN - 32'h1);
    rd(DSC_ADDR_PROFILE_DECEL, v);
    wr(DSC_ADDR_PROFILE_DECEL, DSC_RAMP_MAX + 32'h1);
    rd(16'h0620, 32'h0);
    rd(DSC_ADDR_PROFILE_DECEL, v);
    wr(DSC_ADDR_PROFILE_DECEL, DSC_RAMP_MAX);
    q = 32'd2_000_000 + seed % 32'd1_000_000;
    wr(DSC_ADDR_QUICK_STOP_DECEL, q);
    rd(DSC_ADDR_QUICK_STOP_DECEL, q);
    $display("register test done");
    ref_speed_in = 16'h5 + 16'(seed % 16);
    tgt = target(ref_speed_in);
    for (int i = 0; i < 20 && speed_out !== tgt; i++) tick();
    check("run speed", 64'(tgt), 64'(speed_out));
    halt_sw_in = 1'b1;
    tick(2);
    check("halt ramp", 64'(DSC_RAMP_MAX), 64'(ramp_out));
    for (int i = 0; i < 100 && adj_out !== 1'b1; i++) tick();
    check("adjust pulse", 1, 64'(adj_out));
    tick();
    check("hold", 64'h3, 64'({pos_ctrl_out, power_out}));
    halt_pin_in = 2'b10;
    tick(3);
    halt_sw_in = 1'b0;
    tick(5);
    check("halt kept", 3, 64'({st.halt_active, pos_ctrl_out}));
    halt_pin_in = 2'b00;
    tick(4);
    check("halt released", 0, 64'({st.halt_active, pos_ctrl_out}));
    for (int i = 0; i < 20 && speed_out !== tgt; i++) tick();
    halt_pin_in = 2'b01;
    tick(8);
    s = speed_out;
    check("pin halt slows", 1, 64'(s < tgt));
    halt_pin_in = 2'b00;
    tick(6);
    check("resume", 1, 64'(speed_out > s));
    $display("halt test done");
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 20 && speed_out !== tgt; i++) tick();
      event_in = dsc_event_t'(4'b1000 >> k);
      tick();
      event_in = '0;
      tick();
      check("quick stop on", 1, 64'(st.quick_stop_active));
      check("quick stop ramp", 64'(q), 64'(ramp_out));
      for (int i = 0; i < 150 && speed_out !== '0; i++) tick();
      tick(3);
      check("power after stop", k == 2 ? 0 : 1, 64'(power_out));
      tick(10);
      check("latched", 1, 64'(st.quick_stop_active));
      event_in.fault_reset = 1'b1;
      tick();
      event_in = '0;
      tick(2);
      check("cleared", 64'h1, 64'({st.quick_stop_active, power_out}));
    end
    $display("quick stop test done");
    for (int i = 0; i < 20 && speed_out !== tgt; i++) tick();
    halt_sw_in = 1'b1;
    trip = 1'b1;
    for (int i = 0; i < 50 && st.dc_overvolt_fault !== 1'b1; i++) tick();
    check("coast", 64'h1, 64'({power_out, speed_out == '0}));
    trip = 1'b0;
    halt_sw_in = 1'b0;
    tick(3);
    event_in.fault_reset = 1'b1;
    tick();
    event_in = '0;
    tick(2);
    check("fault cleared", 0, 64'(st.dc_overvolt_fault));
    $display("overvoltage test done");
    test_done();
  end
endmodule
